// [tpc_pkg.sv]
// Purpose: Shared constants and carrier structs for the three-synthesizer clock router control
// Assumes: Synthesizer loops and the oscillator are analog models outside this logic
// Notes:   Settings arrive from nonvolatile configuration as plain ports
package tpc_pkg;

  // ************************************************************
  // Widths and encodings
  // ************************************************************
  localparam int unsigned PREDIV_W    = 8;
  localparam int unsigned FBDIV_W     = 11;
  localparam int unsigned POSTDIV_W   = 7;
  localparam int unsigned CAPLOAD_W   = 6;
  localparam int unsigned DRIVE_W     = 2;
  localparam int unsigned NUM_SYNTH   = 3;
  localparam int unsigned NUM_OUT     = 3;
  localparam int unsigned SRC_W       = 2;

  // Crosspoint source codes
  localparam logic [1:0] SRC_REF      = 2'h0;
  localparam logic [1:0] SRC_SYNTH1   = 2'h1;
  localparam logic [1:0] SRC_SYNTH2   = 2'h2;
  localparam logic [1:0] SRC_SYNTH3   = 2'h3;

  // Divider constants
  localparam logic [6:0] DIV_ONE      = 7'h01;
  localparam logic [6:0] CNT_ZERO     = 7'h00;

  // Lock wait after shutdown exit, 3 ms at 25 MHz
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned LOCK_TIME_US = 3000;
  localparam int unsigned LOCK_CYCLES = (CLK_HZ / 1_000_000) * LOCK_TIME_US;
  localparam int unsigned LOCK_W      = 17;

  // Control pin function
  typedef enum logic [1:0] {
    TPC_PIN_FSEL,
    TPC_PIN_SUSPEND,
    TPC_PIN_OE,
    TPC_PIN_SHUTDOWN
  } tpc_pin_e;

  // ************************************************************
  // Configuration carriers
  // ************************************************************
  typedef struct packed {
    logic [PREDIV_W-1:0] prediv;
    logic [FBDIV_W-1:0]  fbdiv;
  } tpc_synth_cfg_s;

  typedef struct packed {
    tpc_pin_e                pin_func;
    logic                    fsel_with_suspend;
    logic [NUM_SYNTH-1:0]    susp_synth;
    logic [NUM_OUT-1:0]      susp_out;
    logic [NUM_OUT-1:0]      out_invert;
    logic [NUM_OUT*2-1:0]    out_src;
    tpc_synth_cfg_s          synth1_alt;
    logic [POSTDIV_W-1:0]    div_a0;
    logic [POSTDIV_W-1:0]    div_a1;
    logic [POSTDIV_W-1:0]    div_b0;
    logic [POSTDIV_W-1:0]    div_b1;
    logic [POSTDIV_W-1:0]    div_c;
    logic [CAPLOAD_W-1:0]    cap_load;
    logic [DRIVE_W-1:0]      xtal_drive;
    logic                    cap_bypass;
  } tpc_cfg_s;

endpackage

// [tpc_clock_router.sv]
// Purpose: Control pin decode, crosspoint, post dividers and oscillator settings
// Assumes: Source clocks are sampled as levels on i_clk_sys; they run well below it
// Notes:   Post dividers count source edges; output transitions on source edges, except a forced low while out_off or the source is not valid
//
// Contract
// [R1] Synth frequency is reference over predivider times feedback
// [R2] Control pin serves one of four functions
// [R3] Frequency select picks synth1 and A/B settings
// [R4] Divider changes from select are glitch free
// [R5] Output enable low tri-states every output
// [R6] Shutdown low stops everything, tri-states outputs
// [R7] Synths reacquire lock after leaving shutdown
// [R8] Suspend low disables configured synths and outputs
// [R9] Config never suspends synth feeding active output
// [R10] Suspended synth stopped, suspended output tri-stated
// [R11] Suspend may act together with frequency select
// [R12] Six-bit crystal load capacitance setting
// [R13] Configurable oscillator drive strength
// [R14] Load capacitors bypassable for driven reference
// [R15] Crosspoint routes four sources to three outputs
// [R16] A and B dividers chosen by frequency select
// [R17] C divider from single register
// [R18] Output may take inverted synth phase
// [R19] Divide by stored value; one passes through
`timescale 1ns/1ps
module tpc_clock_router (
  // Clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_resetn,
  // Nonvolatile configuration
  input  wire tpc_pkg::tpc_cfg_s             i_cfg,
  input  wire tpc_pkg::tpc_synth_cfg_s       i_synth_cfg [tpc_pkg::NUM_SYNTH],
  // Multi-purpose control pin
  input  wire logic                          i_freq_select_input,
  // Reference and synthesizer clocks, sampled
  input  wire logic                          i_crystal_input_pin,
  input  wire logic [tpc_pkg::NUM_SYNTH-1:0] i_synth_clk,
  input  wire logic [tpc_pkg::NUM_SYNTH-1:0] i_synth_locked,
  // Synthesizer control
  output logic      [tpc_pkg::NUM_SYNTH-1:0] o_synth_run,
  output tpc_pkg::tpc_synth_cfg_s            o_synth_set [tpc_pkg::NUM_SYNTH],
  output logic      [tpc_pkg::NUM_SYNTH-1:0] o_synth_valid,
  // Oscillator control
  output logic                               o_osc_run,
  output logic      [tpc_pkg::CAPLOAD_W-1:0] o_cap_load,
  output logic      [tpc_pkg::DRIVE_W-1:0]   o_xtal_drive,
  output logic                               o_cap_bypass,
  // Clock outputs, two signals per pin
  output logic                               o_first_clock_output,
  output logic                               o_first_clock_output_oe,
  output logic                               o_second_clock_output,
  output logic                               o_second_clock_output_oe,
  output logic                               o_third_clock_output,
  output logic                               o_third_clock_output_oe
);
  import tpc_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [NUM_SYNTH+1:0] meta_q;
  logic [NUM_SYNTH+1:0] sync_q;
  logic [NUM_SYNTH-1:0] lock_meta_q;
  logic [NUM_SYNTH-1:0] lock_sync_q;

  // Pin, reference and synth clocks all come from outside this domain
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q      <= '0;
      sync_q      <= '0;
      lock_meta_q <= '0;
      lock_sync_q <= '0;
    end else begin
      // Reference in bit 0 so the crosspoint source code indexes the level directly
      meta_q      <= {i_freq_select_input, i_synth_clk, i_crystal_input_pin}; // R15
      sync_q      <= meta_q;
      lock_meta_q <= i_synth_locked;
      lock_sync_q <= lock_meta_q;
    end
  end

  logic                 pin_lvl;
  logic [NUM_SYNTH:0]   src_lvl;
  assign pin_lvl = sync_q[NUM_SYNTH+1];
  assign src_lvl = sync_q[NUM_SYNTH:0];

  // ************************************************************
  // Control pin decode
  // ************************************************************
  logic fsel_act;
  logic susp_act;
  logic oe_off;
  logic shut_act;

  // One function per configuration; suspend may ride along with select
  always_comb begin
    fsel_act = 1'b0;
    susp_act = 1'b0;
    oe_off   = 1'b0;
    shut_act = 1'b0;
    unique case (i_cfg.pin_func) // R2
      TPC_PIN_FSEL: begin
        fsel_act = pin_lvl; // R3
        susp_act = i_cfg.fsel_with_suspend & ~pin_lvl; // R11
      end
      TPC_PIN_SUSPEND:  susp_act = ~pin_lvl; // R8
      TPC_PIN_OE:       oe_off   = ~pin_lvl; // R5
      TPC_PIN_SHUTDOWN: shut_act = ~pin_lvl; // R6
    endcase
  end

  // Configuration is trusted to suspend every output of a suspended synth
  logic [NUM_SYNTH-1:0] synth_off;
  logic [NUM_OUT-1:0]   out_off;
  assign synth_off = {NUM_SYNTH{shut_act}} | ({NUM_SYNTH{susp_act}} & i_cfg.susp_synth); // R10 R9
  assign out_off   = {NUM_OUT{shut_act | oe_off}} | ({NUM_OUT{susp_act}} & i_cfg.susp_out); // R10

  // ************************************************************
  // Synthesizer and oscillator control
  // ************************************************************
  logic [LOCK_W-1:0] lock_cnt_q [NUM_SYNTH];

  // Divider settings; synth1 takes its alternate set under select
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_SYNTH; i++) begin
        o_synth_set[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_SYNTH; i++) begin
        o_synth_set[i] <= i_synth_cfg[i]; // R1
      end
      if (fsel_act) begin
        o_synth_set[0] <= i_cfg.synth1_alt; // R3
      end
    end
  end

  // Run enables; oscillator stops only in shutdown
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_synth_run  <= '0;
      o_osc_run    <= 1'b0;
      o_cap_load   <= '0;
      o_xtal_drive <= '0;
      o_cap_bypass <= 1'b0;
    end else begin
      o_synth_run  <= ~synth_off; // R6 R10
      o_osc_run    <= ~shut_act; // R6
      o_cap_load   <= i_cfg.cap_load; // R12
      o_xtal_drive <= i_cfg.xtal_drive; // R13
      o_cap_bypass <= i_cfg.cap_bypass; // R14
    end
  end

  // Lock wait: a synth counts as a source only after lock plus settle time
  genvar g;
  generate
    for (g = 0; g < NUM_SYNTH; g++) begin : g_lock
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          lock_cnt_q[g]    <= '0;
          o_synth_valid[g] <= 1'b0;
        end else if (synth_off[g] || !lock_sync_q[g]) begin
          lock_cnt_q[g]    <= '0; // R7
          o_synth_valid[g] <= 1'b0;
        end else if (lock_cnt_q[g] == LOCK_W'(LOCK_CYCLES - 1)) begin
          o_synth_valid[g] <= 1'b1; // R7
        end else begin
          lock_cnt_q[g] <= lock_cnt_q[g] + LOCK_W'(1);
        end
      end
    end
  endgenerate

  // ************************************************************
  // Crosspoint and post dividers
  // ************************************************************
  function automatic logic [POSTDIV_W-1:0] pick_div(input int unsigned idx, input logic sel);
    logic [POSTDIV_W-1:0] d;
    d = i_cfg.div_c; // R17
    if (idx == 0) begin
      d = sel ? i_cfg.div_a1 : i_cfg.div_a0; // R16
    end else if (idx == 1) begin
      d = sel ? i_cfg.div_b1 : i_cfg.div_b0; // R16
    end
    return (d == CNT_ZERO) ? DIV_ONE : d;
  endfunction

  logic [NUM_OUT-1:0]   clk_q;
  logic [NUM_OUT-1:0]   oe_q;
  logic [NUM_OUT-1:0]   src_prev_q;

  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      logic [POSTDIV_W-1:0] cnt_q;
      logic [POSTDIV_W-1:0] div_q;
      logic                 src;
      logic                 edge_seen;
      logic                 src_ok;
      logic [SRC_W-1:0]     sel;

      assign sel       = i_cfg.out_src[g*SRC_W +: SRC_W];
      assign src       = src_lvl[sel] ^ i_cfg.out_invert[g]; // R15 R18
      assign edge_seen = src & ~src_prev_q[g];
      assign src_ok    = (sel == SRC_REF) ? !shut_act : o_synth_valid[sel - SRC_SYNTH1];

      // Divider runs on source edges; new value loads at period end, on low source cycles when dividing by one, and every cycle while held off
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          cnt_q         <= CNT_ZERO;
          div_q         <= DIV_ONE;
          clk_q[g]      <= 1'b0;
          src_prev_q[g] <= 1'b0;
        end else begin
          src_prev_q[g] <= src;
          if (!src_ok || out_off[g]) begin
            cnt_q    <= CNT_ZERO;
            clk_q[g] <= 1'b0;
            div_q    <= pick_div(g, fsel_act);
          end else if (div_q == DIV_ONE) begin
            clk_q[g] <= src; // R19
            if (!src) begin
              div_q <= pick_div(g, fsel_act); // R4
            end
          end else if (edge_seen) begin
            if (cnt_q == div_q - DIV_ONE) begin
              cnt_q    <= CNT_ZERO;
              clk_q[g] <= 1'b1;
              div_q    <= pick_div(g, fsel_act); // R4
            end else begin
              cnt_q <= cnt_q + DIV_ONE;
              if (cnt_q == (div_q >> 1) - DIV_ONE) begin
                clk_q[g] <= 1'b0; // R19
              end
            end
          end
        end
      end

      // Enable drops with the tri-state controls
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          oe_q[g] <= 1'b0;
        end else begin
          oe_q[g] <= ~out_off[g]; // R5 R6 R10
        end
      end
    end
  endgenerate

  // Straight from the flops
  assign o_first_clock_output     = clk_q[0];
  assign o_first_clock_output_oe  = oe_q[0];
  assign o_second_clock_output    = clk_q[1];
  assign o_second_clock_output_oe = oe_q[1];
  assign o_third_clock_output     = clk_q[2];
  assign o_third_clock_output_oe  = oe_q[2];

endmodule

// [tpc_router_props.sv]
// Purpose: Assertions on pin decode, power states and setting copies
// Assumes: Pin level reaches the outputs three edges after it settles
// Notes:   Sees only router ports; bound after the module
`timescale 1ns/1ps
module tpc_router_props (
  // Clock, reset and settings
  input wire logic                    i_clk_sys,
  input wire logic                    i_resetn,
  input wire tpc_pkg::tpc_cfg_s       i_cfg,
  input wire tpc_pkg::tpc_synth_cfg_s i_synth_cfg [3],
  input wire logic                    i_freq_select_input,
  input wire logic [2:0]              i_synth_locked,
  // Watched outputs
  input wire logic [2:0]              o_synth_run,
  input wire tpc_pkg::tpc_synth_cfg_s o_synth_set [3],
  input wire logic [2:0]              o_synth_valid,
  input wire logic                    o_osc_run,
  input wire logic [5:0]              o_cap_load,
  input wire logic [1:0]              o_xtal_drive,
  input wire logic                    o_cap_bypass,
  input wire logic                    o_first_clock_output_oe,
  input wire logic                    o_second_clock_output_oe,
  input wire logic                    o_third_clock_output_oe
);
  import tpc_pkg::*;
  wire [2:0] oe = {o_third_clock_output_oe, o_second_clock_output_oe, o_first_clock_output_oe};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // Pin held long enough to cross the two-flop synchronizer
  sequence s_held(tpc_pin_e f, logic lv);
    (i_cfg.pin_func == f && i_freq_select_input == lv) [*3];
  endsequence
  a_oe_off: assert property (s_held(TPC_PIN_OE, 1'b0) |=> oe == 3'h0) else $error("oe still on");
  a_oe_on: assert property (s_held(TPC_PIN_OE, 1'b1) |=> oe == 3'h7) else $error("oe still off");
  a_sd_stop: assert property (s_held(TPC_PIN_SHUTDOWN, 1'b0) |=> !o_osc_run && {o_synth_run, oe} == 6'h00)
    else $error("shutdown left something on");
  a_sd_wake: assert property (s_held(TPC_PIN_SHUTDOWN, 1'b1) |=> o_osc_run) else $error("osc stopped");
  a_susp_out: assert property (s_held(TPC_PIN_SUSPEND, 1'b0) |=> (oe & i_cfg.susp_out) == 3'h0)
    else $error("suspended output driven");
  a_susp_syn: assert property (s_held(TPC_PIN_SUSPEND, 1'b0) |=> (o_synth_run & i_cfg.susp_synth) == 3'h0)
    else $error("suspended synth runs");
  a_fs_alt: assert property (s_held(TPC_PIN_FSEL, 1'b1) |=> o_synth_set[0] == i_cfg.synth1_alt)
    else $error("alt synth setting missing");
  a_fs_norm: assert property (s_held(TPC_PIN_FSEL, 1'b0) |=> o_synth_set[0] == i_synth_cfg[0])
    else $error("base synth setting missing");
  a_lock_wait: assert property (!i_synth_locked[0] [*3] |=> !o_synth_valid[0]) else $error("valid w/o lock");
  a_osc_copy: assert property ($stable(i_cfg) [*2] |=>
    {o_cap_load, o_xtal_drive, o_cap_bypass} == {i_cfg.cap_load, i_cfg.xtal_drive, i_cfg.cap_bypass})
    else $error("oscillator setting differs");
endmodule
bind tpc_clock_router tpc_router_props u_props (.i_clk_sys, .i_resetn, .i_cfg, .i_synth_cfg,
  .i_freq_select_input, .i_synth_locked, .o_synth_run, .o_synth_set, .o_synth_valid, .o_osc_run,
  .o_cap_load, .o_xtal_drive, .o_cap_bypass, .o_first_clock_output_oe, .o_second_clock_output_oe,
  .o_third_clock_output_oe);

// [tpc_load_model.sv]
// Purpose: Clocked loads that time the three output pins
// Assumes: Each pin has a pull-down, so a released pin reads low
// Notes:   First edge after a restart only opens a period
`timescale 1ns/1ps
module tpc_load_model (
  // Clock and measurement restart
  input  wire logic       i_clk_sys,
  input  wire logic       i_clr,
  // Pins as the loads see them
  input  wire logic [2:0] i_clk_out,
  input  wire logic [2:0] i_oe,
  // Last period, shortest period and rising edges per load
  output int              o_per [3],
  output int              o_min [3],
  output int              o_edges [3]
);
  logic [2:0] line_q = 3'h0;
  int         cnt [3];
  // Shortest period exposes any runt pulse left by a divider switch
  always @(posedge i_clk_sys) begin
    for (int k = 0; k < 3; k++) begin
      cnt[k] = i_clr ? 0 : cnt[k] + 1;
      if (i_clr) begin
        o_edges[k] = 0;
        o_min[k] = 9999;
      end else if ((i_oe[k] & i_clk_out[k]) === 1'b1 && line_q[k] === 1'b0) begin
        if (o_edges[k] > 0) begin
          o_per[k] = cnt[k];
          o_min[k] = (cnt[k] < o_min[k]) ? cnt[k] : o_min[k];
        end
        o_edges[k] = o_edges[k] + 1;
        cnt[k] = 0;
      end
    end
    line_q <= i_oe & i_clk_out;
  end
endmodule

// [test_three_pll_clock_router_control.sv]
// Purpose: Self-checking bench for the clock router control
// Assumes: Reference period is 8 system cycles; loops never report lock
// Notes:   Reference routing keeps sources valid without the long lock wait
`timescale 1ns/1ps
module test_three_pll_clock_router_control;
  import tpc_pkg::*;
  logic           clk = 1'b0, rstn = 1'b0, pin = 1'b0, ref_clk = 1'b0, clr = 1'b1;
  logic [2:0]     sclk = 3'h0, run, valid, co, oe;
  logic           osc, byp;
  logic [5:0]     cap;
  logic [1:0]     drv;
  tpc_cfg_s       cfg = '0;
  tpc_synth_cfg_s scfg [NUM_SYNTH] = '{default: 19'h0ABCD};
  tpc_synth_cfg_s sset [NUM_SYNTH];
  int             per_v [3], min_v [3], edg [3];
  int             error_cnt = 0, cmp_count = 0;
  // Clocks; the reference changes on the falling edge, loop clocks stay quiet so routing is visible
  initial forever #20 clk = ~clk;
  initial forever begin
    repeat (4) @(negedge clk);
    ref_clk = ~ref_clk;
  end
  tpc_clock_router i_dut (.i_clk_sys(clk), .i_resetn(rstn), .i_cfg(cfg), .i_synth_cfg(scfg),
    .i_freq_select_input(pin), .i_crystal_input_pin(ref_clk), .i_synth_clk(sclk), .i_synth_locked(3'h0),
    .o_synth_run(run), .o_synth_set(sset), .o_synth_valid(valid), .o_osc_run(osc), .o_cap_load(cap),
    .o_xtal_drive(drv), .o_cap_bypass(byp), .o_first_clock_output(co[0]), .o_first_clock_output_oe(oe[0]),
    .o_second_clock_output(co[1]), .o_second_clock_output_oe(oe[1]), .o_third_clock_output(co[2]),
    .o_third_clock_output_oe(oe[2]));
  tpc_load_model i_load (.i_clk_sys(clk), .i_clr(clr), .i_clk_out(co), .i_oe(oe), .o_per(per_v),
    .o_min(min_v), .o_edges(edg));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Dividers A 3/2, B 1/7, C 5; all outputs from the reference
  function automatic tpc_cfg_s base(input tpc_pin_e f);
    base = '0;
    base.pin_func = f;
    {base.div_a0, base.div_a1, base.div_b0, base.div_b1, base.div_c} = {7'h03, 7'h02, 7'h01, 7'h07, 7'h05};
    {base.cap_load, base.xtal_drive, base.cap_bypass, base.synth1_alt} = {6'h2A, 2'h2, 1'b1, 19'h2A5A5};
  endfunction
  // Reset held 4 cycles while the new setting is applied
  task automatic restart(input tpc_cfg_s c, input logic lv);
    rstn = 1'b0;
    cfg = c;
    pin = lv;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic setp(input logic lv);
    pin = lv;
    repeat (6) @(negedge clk);
  endtask
  // Restart timing, set the pin, then judge last and shortest period
  task automatic per(input int k, input logic pv, input int exp, input int lo);
    int t;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    pin = pv;
    for (t = 0; t < 1000 && edg[k] < 4; t++) @(negedge clk);
    if (t == 1000) begin
      error_cnt++;
      finish_test();
    end
    chk(per_v[k], exp);
    chk(min_v[k] >= lo, 1);
  endtask
  initial begin
    tpc_cfg_s c;
    @(negedge clk);
    restart(base(TPC_PIN_OE), 1'b1);
    chk(oe, 3'h7);
    chk({cap, drv, byp}, {6'h2A, 2'h2, 1'b1});
    per(2, 1'b1, 40, 40);
    setp(1'b0);
    chk({oe, co}, 6'h00);
    restart(base(TPC_PIN_SHUTDOWN), 1'b1);
    chk(osc, 1'b1);
    setp(1'b0);
    chk({osc, run, oe}, 7'h00);
    setp(1'b1);
    chk({osc, valid}, 4'h8);
    // Suspend alone, then together with frequency select
    for (int m = 0; m < 2; m++) begin
      c = base(m ? TPC_PIN_FSEL : TPC_PIN_SUSPEND);
      {c.fsel_with_suspend, c.susp_out, c.susp_synth} = {1'b1, 3'h3, 3'h1};
      restart(c, 1'b1);
      chk({run, oe}, 6'h3F);
      setp(1'b0);
      chk({run, oe}, 6'h34);
    end
    restart(base(TPC_PIN_FSEL), 1'b0);
    chk(sset[0], scfg[0]);
    chk(sset[2], scfg[2]);
    per(1, 1'b0, 8, 8);
    per(0, 1'b1, 16, 16);
    chk(sset[0], 19'h2A5A5);
    per(1, 1'b1, 56, 56);
    per(2, 1'b1, 40, 40);
    per(0, 1'b0, 24, 16);
    // Unlocked loops on A and C stay silent; B from the reference in either field order
    c = base(TPC_PIN_OE);
    c.out_src = {SRC_SYNTH3, SRC_REF, SRC_SYNTH1};
    restart(c, 1'b1);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (200) @(negedge clk);
    chk(edg[0] + edg[2], 0);
    chk(edg[1] > 3, 1);
    finish_test();
  end
endmodule
